// [hdl/ser_pkg.sv]
// package for the status/event reporting block: command codes, bit positions, masks
// assumes a command decoder upstream presents one status command per strobe
package ser_pkg;
  // status command codes on the command port
  typedef enum logic [3:0] {
    SER_CMD_NONE     = 4'h0, // idle
    SER_CMD_COND_RD  = 4'h1, // read operation condition
    SER_CMD_EVT_RD   = 4'h2, // read and clear operation event latch
    SER_CMD_ENA_WR   = 4'h3, // write operation enable mask
    SER_CMD_ENA_RD   = 4'h4, // read operation enable mask
    SER_CMD_RISE_WR  = 4'h5, // write rising edge mask
    SER_CMD_FALL_WR  = 4'h6, // write falling edge mask
    SER_CMD_RISE_RD  = 4'h7, // read rising edge mask
    SER_CMD_FALL_RD  = 4'h8, // read falling edge mask
    SER_CMD_STD_RD   = 4'h9, // read and clear standard event latch
    SER_CMD_SENA_WR  = 4'hA, // write standard event enable mask
    SER_CMD_SENA_RD  = 4'hB, // read standard event enable mask
    SER_CMD_CLS      = 4'hC, // clear status
    SER_CMD_PRESET   = 4'hD, // status preset
    SER_CMD_RST      = 4'hE, // device reset
    SER_CMD_OPC      = 4'hF  // operation complete
  } ser_cmd_e;
  localparam int SER_OP_W = 16; // operation group width
  localparam int SER_STD_W = 8; // standard event width
  // live operation condition positions
  localparam logic [15:0] SER_OP_LIVE = 16'h0341;
  localparam int SER_OP_CAL_BIT = 0;
  localparam int SER_OP_ARM_BIT = 6;
  localparam int SER_OP_BUSY_BIT = 8;
  localparam int SER_OP_READY_BIT = 9;
  // standard event bit positions
  localparam int SER_PWR_BIT = 7;
  localparam int SER_CME_BIT = 5;
  localparam int SER_EXE_BIT = 4;
  localparam int SER_DDE_BIT = 3;
  localparam int SER_QYE_BIT = 2;
  localparam int SER_OPC_BIT = 0;
  localparam logic [7:0] SER_STD_LIVE = 8'hBD; // bits 6 and 1 unused
  // reset and preset values
  localparam logic [15:0] SER_OP_ZERO = 16'h0000;
  localparam logic [15:0] SER_OP_ONES = 16'hFFFF;
  localparam logic [7:0] SER_STD_ZERO = 8'h00;
endpackage

// [hdl/ser_status.sv]
// status/event reporting: operation group and standard event group with summaries
// assumes a same-clock command strobe and arm-wait entry pulse; other condition sources are asynchronous pins
`timescale 1ns/10ps

// Summary of operation
// (R1) condition live only at bits 0,6,8,9
// (R2) condition reads never alter bits
// (R3) device reset clears condition bits
// (R4) falling mask sets event on 1-to-0
// (R5) rising mask sets event on 0-to-1
// (R6) events latch until read or clear
// (R7) operation summary is OR of event&enable
// (R8) host writes enable mask, ones unmask
// (R9) power-on sets standard bit 7
// (R10) bad header/command sets standard bit 5
// (R11) out-of-range parameter sets standard bit 4
// (R12) other device error sets standard bit 3
// (R13) query errors set standard bit 2
// (R14) operation-complete command sets standard bit 0
// (R15) standard register 8 bits, 6 and 1 unused
// (R16) standard latch clears power-on, read, clear
// (R17) standard summary is OR of event&enable
// (R18) standard enable mask reads back
// (R19) standard enable clears power-on or zero write
// (R20) arm-wait bit high until arm/abort
// (R21) preset zeroes enable, rising-only filter
// (R22) edges found against previous-cycle value
// (R23) new event beats clearing read
module ser_status (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire ser_pkg::ser_cmd_e cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] rsp_data,
  output logic rsp_valid,
  input wire logic cal_active,
  input wire logic arm_wait_enter,
  input wire logic arm_start,
  input wire logic meas_abort,
  input wire logic busy_active,
  input wire logic ready_active,
  input wire logic command_error_flag,
  input wire logic execution_error_flag,
  input wire logic device_specific_error_flag,
  input wire logic query_error_flag,
  output logic op_summary,
  output logic std_summary
);
  import ser_pkg::*;

  // set-over-clear latch update, shared by both event registers
  function automatic logic [15:0] latch_upd(input logic [15:0] cur, input logic [15:0] set,
                                            input logic clr);
    latch_upd = (clr ? 16'h0000 : cur) | set;
  endfunction

  // pin synchronisers: first stage read only by the second
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_raw;
  assign pin_raw = {ready_active, busy_active, meas_abort, arm_start, cal_active};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // command decode
  // unknown codes decode to nothing and get no answer
  wire cmd_rst = cmd_valid && (cmd_code == SER_CMD_RST);
  wire cmd_cls = cmd_valid && (cmd_code == SER_CMD_CLS);
  wire cmd_pre = cmd_valid && (cmd_code == SER_CMD_PRESET);
  wire cmd_evt_rd = cmd_valid && (cmd_code == SER_CMD_EVT_RD);
  wire cmd_std_rd = cmd_valid && (cmd_code == SER_CMD_STD_RD);
  wire cmd_ena_wr = cmd_valid && (cmd_code == SER_CMD_ENA_WR);
  wire cmd_rise_wr = cmd_valid && (cmd_code == SER_CMD_RISE_WR);
  wire cmd_fall_wr = cmd_valid && (cmd_code == SER_CMD_FALL_WR);
  wire cmd_sena_wr = cmd_valid && (cmd_code == SER_CMD_SENA_WR);
  wire cmd_opc = cmd_valid && (cmd_code == SER_CMD_OPC); // R14

  // arm-wait flag: entry is a same-clock pulse from the measurement sequencer,
  // start arm and abort come through the pin synchronisers
  logic arm_wait_r; // condition bit 6 source
  logic arm_wait_nxt; // next value of the flag
  wire arm_clr = pin_s2_r[1] || pin_s2_r[2] || cmd_rst; // R20 R3
  // entry beats a clear in the same cycle: a new wait must not be missed,
  // and the synchronised start arm may still be high from the last run
  assign arm_wait_nxt = arm_wait_enter ? 1'b1 : // R20
                        (arm_clr ? 1'b0 : arm_wait_r); // R20

  // flag register, plain reset only
  always_ff @(posedge clk) begin
    if (!rstn) arm_wait_r <= 1'b0;
    else arm_wait_r <= arm_wait_nxt;
  end

  // live condition word, unused positions tied low
  logic [15:0] cond_live;
  always_comb begin
    cond_live = SER_OP_ZERO;
    cond_live[SER_OP_CAL_BIT] = pin_s2_r[0];
    cond_live[SER_OP_ARM_BIT] = arm_wait_r;
    cond_live[SER_OP_BUSY_BIT] = pin_s2_r[3];
    cond_live[SER_OP_READY_BIT] = pin_s2_r[4];
  end

  // device reset masks the condition for one cycle so it reads zero
  // a condition still high returns next cycle and counts as a new edge
  logic [15:0] cond_r;
  always_ff @(posedge clk) begin
    if (!rstn) cond_r <= SER_OP_ZERO;
    else if (cmd_rst) cond_r <= SER_OP_ZERO; // R3
    else cond_r <= cond_live & SER_OP_LIVE; // R1
  end

  // previous condition for edge detection
  logic [15:0] cond_prev_r;
  always_ff @(posedge clk) begin
    if (!rstn) cond_prev_r <= SER_OP_ZERO;
    else cond_prev_r <= cond_r; // R22
  end

  // transition filter masks
  logic [15:0] rise_mask_r;
  logic [15:0] fall_mask_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rise_mask_r <= SER_OP_ONES;
      fall_mask_r <= SER_OP_ZERO;
    end else if (cmd_pre) begin
      rise_mask_r <= SER_OP_ONES; // R21
      fall_mask_r <= SER_OP_ZERO; // R21
    end else begin
      if (cmd_rise_wr) rise_mask_r <= cmd_wdata & SER_OP_LIVE;
      if (cmd_fall_wr) fall_mask_r <= cmd_wdata & SER_OP_LIVE;
    end
  end

  // edge events, each lasting exactly one cycle
  wire [15:0] rise_hit = cond_r & ~cond_prev_r & rise_mask_r; // R5 R22
  wire [15:0] fall_hit = ~cond_r & cond_prev_r & fall_mask_r; // R4 R22
  wire [15:0] op_set = rise_hit | fall_hit;

  // operation event latch; clear by read or clear-status, set wins
  logic [15:0] op_evt_r;
  always_ff @(posedge clk) begin
    if (!rstn) op_evt_r <= SER_OP_ZERO;
    else op_evt_r <= latch_upd(op_evt_r, op_set, cmd_evt_rd || cmd_cls); // R6 R23
  end

  // operation enable mask, written by host
  // full 16-bit store: unused positions are harmless, their events never set
  logic [15:0] op_ena_r;
  always_ff @(posedge clk) begin
    if (!rstn) op_ena_r <= SER_OP_ZERO;
    else if (cmd_pre) op_ena_r <= SER_OP_ZERO; // R21
    else if (cmd_ena_wr) op_ena_r <= cmd_wdata; // R8
  end

  // operation-complete is a same-clock strobe from the command decode
  logic operation_complete_flag;
  assign operation_complete_flag = cmd_opc; // R14

  // standard event sources, only live positions may set
  logic [7:0] std_set;
  always_comb begin
    std_set = SER_STD_ZERO;
    std_set[SER_CME_BIT] = command_error_flag; // R10
    std_set[SER_EXE_BIT] = execution_error_flag; // R11
    std_set[SER_DDE_BIT] = device_specific_error_flag; // R12
    std_set[SER_QYE_BIT] = query_error_flag; // R13
    std_set[SER_OPC_BIT] = operation_complete_flag; // R14
  end

  // power-on: flag high while reset is held and in the first cycle after reset release
  logic power_on_flag;
  logic pon_done_r;
  always_ff @(posedge clk) begin
    if (!rstn) pon_done_r <= 1'b0;
    else pon_done_r <= 1'b1;
  end
  assign power_on_flag = !pon_done_r; // R9

  logic [7:0] std_evt_r;
  wire [7:0] std_set_all = (std_set | {power_on_flag, 7'h00}) & SER_STD_LIVE; // R9 R15
  wire [15:0] std_next = latch_upd({8'h00, std_evt_r}, {8'h00, std_set_all},
                                   cmd_std_rd || cmd_cls);
  always_ff @(posedge clk) begin
    if (!rstn) std_evt_r <= SER_STD_ZERO; // R16
    else std_evt_r <= std_next[7:0]; // R16 R23
  end

  // standard enable mask; zero write clears it
  logic [7:0] std_ena_r;
  always_ff @(posedge clk) begin
    if (!rstn) std_ena_r <= SER_STD_ZERO; // R19
    else if (cmd_sena_wr) std_ena_r <= cmd_wdata[7:0]; // R19
  end

  // summaries
  assign op_summary = |(op_evt_r & op_ena_r); // R7
  assign std_summary = |(std_evt_r & std_ena_r); // R17

  // read mux; reads never touch the condition
  logic [15:0] rd_sel;
  always_comb begin
    case (cmd_code)
      SER_CMD_COND_RD: rd_sel = cond_r; // R2
      SER_CMD_EVT_RD: rd_sel = op_evt_r;
      SER_CMD_ENA_RD: rd_sel = op_ena_r;
      SER_CMD_RISE_RD: rd_sel = rise_mask_r;
      SER_CMD_FALL_RD: rd_sel = fall_mask_r;
      SER_CMD_STD_RD: rd_sel = {8'h00, std_evt_r};
      SER_CMD_SENA_RD: rd_sel = {8'h00, std_ena_r}; // R18
      default: rd_sel = SER_OP_ZERO;
    endcase
  end
  wire is_rd = cmd_valid && (cmd_code inside {SER_CMD_COND_RD, SER_CMD_EVT_RD,
    SER_CMD_ENA_RD, SER_CMD_RISE_RD, SER_CMD_FALL_RD, SER_CMD_STD_RD, SER_CMD_SENA_RD});

  // registered answer, one cycle after the command
  // rsp_data holds until the next read, so a slow host can still take it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp_data <= SER_OP_ZERO;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= is_rd;
      if (is_rd) rsp_data <= rd_sel;
    end
  end

  // checks: each watches a register or strobe the logic above drives;
  // all are clocked on clk and idle while reset is held, so the first
  // attempt starts at the first edge after release
  AST_COND_MASK: assert property (@(posedge clk) disable iff (!rstn) // R1
    (cond_r & ~SER_OP_LIVE) == 16'h0000) else $error("unused condition bit set");
  AST_RST_CLR: assert property (@(posedge clk) disable iff (!rstn) // R3
    cmd_rst |=> cond_r == 16'h0000) else $error("device reset left condition");
  AST_RISE: assert property (@(posedge clk) disable iff (!rstn) // R5
    (|rise_hit) |=> (op_evt_r & $past(rise_hit)) == $past(rise_hit))
    else $error("rising event lost");
  AST_FALL: assert property (@(posedge clk) disable iff (!rstn) // R4
    (|fall_hit) |=> (op_evt_r & $past(fall_hit)) == $past(fall_hit))
    else $error("falling event lost");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rstn) // R6
    !cmd_evt_rd && !cmd_cls |=> (op_evt_r & $past(op_evt_r)) == $past(op_evt_r))
    else $error("event bit dropped");
  AST_OPSUM: assert property (@(posedge clk) disable iff (!rstn) // R7
    (|(op_set & op_ena_r)) && !cmd_ena_wr && !cmd_pre |=> op_summary)
    else $error("enabled operation event gave no summary");
  AST_STDSUM: assert property (@(posedge clk) disable iff (!rstn) // R17
    (|(std_set_all & std_ena_r)) && !cmd_sena_wr |=> std_summary)
    else $error("enabled standard event gave no summary");
  AST_STD_UNUSED: assert property (@(posedge clk) disable iff (!rstn) // R15
    (std_evt_r & ~SER_STD_LIVE) == 8'h00) else $error("unused std bit set");
  AST_PRESET: assert property (@(posedge clk) disable iff (!rstn) // R21
    cmd_pre |=> op_ena_r == 16'h0000 && fall_mask_r == 16'h0000)
    else $error("preset failed");
  AST_CME: assert property (@(posedge clk) disable iff (!rstn) // R10
    command_error_flag |=> std_evt_r[SER_CME_BIT]) else $error("command error lost");

  // each other error source lands on its own standard bit
  AST_EXE: assert property (@(posedge clk) disable iff (!rstn) // R11
    execution_error_flag |=> std_evt_r[SER_EXE_BIT])
    else $error("execution error lost");
  AST_DDE: assert property (@(posedge clk) disable iff (!rstn) // R12
    device_specific_error_flag |=> std_evt_r[SER_DDE_BIT])
    else $error("device error lost");
  AST_QYE: assert property (@(posedge clk) disable iff (!rstn) // R13
    query_error_flag |=> std_evt_r[SER_QYE_BIT])
    else $error("query error lost");

  // read-clear paths: after a clearing strobe only same-cycle sets remain
  AST_EVT_CLR: assert property (@(posedge clk) disable iff (!rstn) // R6
    cmd_evt_rd || cmd_cls |=> op_evt_r == $past(op_set))
    else $error("operation event latch not cleared");
  AST_STD_CLR: assert property (@(posedge clk) disable iff (!rstn) // R16
    cmd_std_rd || cmd_cls |=> std_evt_r == $past(std_set_all))
    else $error("standard event latch not cleared");

  // a new event in the cycle of a clearing read must survive it
  AST_KEEP: assert property (@(posedge clk) disable iff (!rstn) // R23
    (|std_set_all) && cmd_std_rd |=>
      (std_evt_r & $past(std_set_all)) == $past(std_set_all))
    else $error("event lost to clearing read");

  // power-on bit appears at the first edge after reset release
  AST_PON: assert property (@(posedge clk) disable iff (!rstn) // R9
    $rose(pon_done_r) |-> std_evt_r[SER_PWR_BIT])
    else $error("power-on bit missing");

  // operation-complete strobe lands on bit 0
  AST_OPC: assert property (@(posedge clk) disable iff (!rstn) // R14
    cmd_opc |=> std_evt_r[SER_OPC_BIT])
    else $error("operation-complete bit missing");

  // a zero write empties the standard enable mask
  AST_SENA_ZERO: assert property (@(posedge clk) disable iff (!rstn) // R19
    cmd_sena_wr && (cmd_wdata[7:0] == 8'h00) |=> std_ena_r == 8'h00)
    else $error("standard enable not cleared by zero write");

  // host writes land whole; edge masks keep only live positions
  AST_ENA_WR: assert property (@(posedge clk) disable iff (!rstn) // R8
    cmd_ena_wr && !cmd_pre |=> op_ena_r == $past(cmd_wdata))
    else $error("operation enable write lost");
  AST_RISE_WR: assert property (@(posedge clk) disable iff (!rstn) // R5
    cmd_rise_wr && !cmd_pre |=> rise_mask_r == ($past(cmd_wdata) & SER_OP_LIVE))
    else $error("rising mask write lost");

  // read answers carry the values sampled with the strobe
  AST_SENA_RD: assert property (@(posedge clk) disable iff (!rstn) // R18
    cmd_valid && (cmd_code == SER_CMD_SENA_RD) |=>
      rsp_valid && (rsp_data == {8'h00, $past(std_ena_r)}))
    else $error("standard enable read back wrong");
  AST_COND_RD: assert property (@(posedge clk) disable iff (!rstn) // R2
    cmd_valid && (cmd_code == SER_CMD_COND_RD) |=>
      rsp_valid && (rsp_data == $past(cond_r)))
    else $error("condition read back wrong");

  // an edge is reported in one cycle only
  AST_RISE_ONCE: assert property (@(posedge clk) disable iff (!rstn) // R22
    (|rise_hit) |=> (rise_hit & $past(rise_hit)) == 16'h0000)
    else $error("rising edge reported twice");
  AST_FALL_ONCE: assert property (@(posedge clk) disable iff (!rstn) // R22
    (|fall_hit) |=> (fall_hit & $past(fall_hit)) == 16'h0000)
    else $error("falling edge reported twice");

  // arm-wait steps: the condition register adds one cycle after the flag,
  // so an entry shows on the condition two edges after the pulse
  sequence arm_enter_s;
    arm_wait_enter ##1 !cmd_rst;
  endsequence
  sequence arm_quit_s;
    arm_clr && !arm_wait_enter;
  endsequence
  AST_ARM_SET: assert property (@(posedge clk) disable iff (!rstn) // R20
    arm_enter_s |=> cond_r[SER_OP_ARM_BIT])
    else $error("arm-wait bit not raised");
  AST_ARM_CLR: assert property (@(posedge clk) disable iff (!rstn) // R20
    arm_quit_s |=> !arm_wait_r)
    else $error("arm-wait bit not cleared");
endmodule

// [sim/ser_host.sv]
// host model: issues one status command at a time and collects the answer
// assumes reads are answered one cycle after the strobe is taken
`timescale 1ns/10ps
module ser_host (
  input wire logic clk,
  output logic cmd_valid,
  output ser_pkg::ser_cmd_e cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_valid
);
  import ser_pkg::*;
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = SER_CMD_NONE;
    cmd_wdata = 16'h0000;
  end
  // one strobe; q carries read data, unknown when no answer came
  task automatic cmd(input ser_cmd_e c, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d; // stale data must never pass for a write
    #1;
    q = rsp_valid ? rsp_data : 16'hXXXX;
  endtask
endmodule

// [sim/tb_ser_status.sv]
// testbench for the status/event block: scenario tasks with self-checks
// assumes the host model above and pins changed on the rising edge
`timescale 1ns/10ps
module tb_ser_status;
  import ser_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] pin = 10'h000; // 3:0 error flags, cal, arm in, arm go, abort, busy, ready
  logic cmd_valid;
  ser_cmd_e cmd_code;
  logic [15:0] cmd_wdata;
  logic [15:0] rsp_data;
  logic rsp_valid;
  logic op_summary;
  logic std_summary;
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  ser_status ser_status_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .cal_active(pin[4]),
    .arm_wait_enter(pin[5]), .arm_start(pin[6]), .meas_abort(pin[7]), .busy_active(pin[8]),
    .ready_active(pin[9]), .command_error_flag(pin[0]), .execution_error_flag(pin[1]),
    .device_specific_error_flag(pin[2]), .query_error_flag(pin[3]),
    .op_summary(op_summary), .std_summary(std_summary));
  ser_host ser_host_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  // summary line, then the verdict
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // the one compare for every result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input ser_cmd_e c, input logic [15:0] exp);
    logic [15:0] q;
    ser_host_i.cmd(c, 16'h0000, q);
    chk(q, exp);
  endtask
  task automatic wr(input ser_cmd_e c, input logic [15:0] d);
    logic [15:0] q;
    ser_host_i.cmd(c, d, q);
  endtask
  task automatic pin_set(input int k, input logic v);
    @(posedge clk);
    pin[k] <= v;
  endtask
  task automatic pulse(input int k);
    pin_set(k, 1'b1);
    pin_set(k, 1'b0);
  endtask
  // polls the condition word; synchroniser delay is not fixed, so bounded
  task automatic cond_is(input logic [15:0] exp);
    logic [15:0] q;
    for (int i = 0; i < 8; i++) begin
      ser_host_i.cmd(SER_CMD_COND_RD, 16'h0000, q);
      if (q === exp) break;
    end
    chk(q, exp);
    if (q !== exp) print_verdict();
  endtask
  // power-on state of the standard latch and standard enable mask
  task automatic t_reset();
    rd(SER_CMD_STD_RD, 16'h0080);
    rd(SER_CMD_STD_RD, 16'h0000);
    rd(SER_CMD_SENA_RD, 16'h0000);
  endtask
  // live bits, rising events, read-clear, arm-wait clearing paths
  task automatic t_cond();
    pin_set(4, 1'b1);
    pin_set(8, 1'b1);
    pin_set(9, 1'b1);
    pulse(5);
    cond_is(16'h0341);
    rd(SER_CMD_COND_RD, 16'h0341);
    rd(SER_CMD_EVT_RD, 16'h0341);
    rd(SER_CMD_EVT_RD, 16'h0000);
    @(posedge clk);
    pin <= 10'h000;
    cond_is(16'h0040);
    wr(SER_CMD_RST, 16'h0000);
    rd(SER_CMD_COND_RD, 16'h0000);
    for (int k = 6; k < 8; k++) begin
      pulse(5);
      cond_is(16'h0040);
      pulse(k);
      cond_is(16'h0000);
    end
    rd(SER_CMD_EVT_RD, 16'h0040);
  endtask
  // falling-only filter, enable mask and operation summary
  task automatic t_fall();
    wr(SER_CMD_RISE_WR, 16'h0000);
    wr(SER_CMD_FALL_WR, 16'h0200);
    pin_set(9, 1'b1);
    cond_is(16'h0200);
    rd(SER_CMD_EVT_RD, 16'h0000);
    pin_set(9, 1'b0);
    cond_is(16'h0000);
    wr(SER_CMD_ENA_WR, 16'h0200);
    chk({15'h0000, op_summary}, 16'h0001);
    rd(SER_CMD_EVT_RD, 16'h0200);
    chk({15'h0000, op_summary}, 16'h0000);
    pin_set(9, 1'b1);
    cond_is(16'h0200);
    pin_set(9, 1'b0);
    cond_is(16'h0000);
    chk({15'h0000, op_summary}, 16'h0001);
    rd(SER_CMD_EVT_RD, 16'h0200);
  endtask
  // each error flag lands on its own standard bit; summary and clears
  task automatic t_std();
    logic [15:0] q;
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rd(SER_CMD_STD_RD, 16'h0020 >> i);
    end
    wr(SER_CMD_SENA_WR, 16'h0020);
    rd(SER_CMD_SENA_RD, 16'h0020);
    pulse(0);
    #1;
    chk({15'h0000, std_summary}, 16'h0001);
    wr(SER_CMD_CLS, 16'h0000);
    chk({15'h0000, std_summary}, 16'h0000);
    // error flag high in the very cycle the clearing read is taken
    fork
      ser_host_i.cmd(SER_CMD_STD_RD, 16'h0000, q);
      pulse(0);
    join
    chk(q, 16'h0000);
    rd(SER_CMD_STD_RD, 16'h0020);
    wr(SER_CMD_OPC, 16'h0000);
    rd(SER_CMD_STD_RD, 16'h0001);
    wr(SER_CMD_SENA_WR, 16'h0000);
    rd(SER_CMD_SENA_RD, 16'h0000);
  endtask
  // preset returns masks to the rising-only, all-masked state
  task automatic t_preset();
    wr(SER_CMD_FALL_WR, 16'hFFFF);
    wr(SER_CMD_PRESET, 16'h0000);
    rd(SER_CMD_ENA_RD, 16'h0000);
    rd(SER_CMD_RISE_RD, 16'hFFFF);
    rd(SER_CMD_FALL_RD, 16'h0000);
  endtask
  // reset for six cycles, then every scenario in turn
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cond();
    t_fall();
    t_std();
    t_preset();
    print_verdict();
  end
endmodule
